// file: fslc_pkg.sv
package fslc_pkg;
  // =====================================================
  // register command codes
  localparam logic [7:0] GAIN_RD_CMD    = 8'had;
  localparam logic [7:0] GAIN_WR_CMD    = 8'hb6;
  localparam logic [7:0] PRESC_RD_CMD   = 8'hbb;
  localparam logic [7:0] PRESC_WR_CMD   = 8'hbc;
  localparam logic [7:0] FSDIV_RD_CMD   = 8'hbf;
  localparam logic [7:0] FSDIV_WR_CMD   = 8'hc0;
  localparam logic [7:0] RATE_RD_CMD    = 8'hc1;
  localparam logic [7:0] RATE_WR_CMD    = 8'hc2;
  localparam logic [7:0] SPEED_RD_CMD   = 8'hab;
  localparam logic [7:0] SPEED_WR_CMD   = 8'hb4;
  localparam logic [7:0] PERIOD_RD_CMD  = 8'hb0;
  localparam logic [7:0] LIMIT_RD_CMD   = 8'hb1;
  localparam logic [7:0] LIMIT_WR_CMD   = 8'hb8;
  // =====================================================
  // field positions and reset values
  localparam int          GAIN_DRV_BIT  = 0;
  localparam int          GAIN_FB_BIT   = 1;
  localparam int          GAIN_KEEP_BIT = 7;
  localparam int          GAIN_LO_BIT   = 5;
  localparam int          GAIN_HI_BIT   = 6;
  localparam logic [7:0]  GAIN_RST      = 8'h80;
  localparam logic [1:0]  GAIN_FLD_RST  = 2'h0;
  localparam logic [7:0]  GAIN_WMASK    = 8'he3;
  localparam logic [7:0]  PRESC_RST     = 8'h01;
  localparam logic [7:0]  FSDIV_RST     = 8'hff;
  localparam logic [7:0]  FSDIV_MIN     = 8'h7f;
  localparam logic [7:0]  RATE_RST      = 8'h02;
  localparam logic [7:0]  LIMIT_RST     = 8'hff;
  localparam logic [6:0]  SPEED_FULL    = 7'h40;
  localparam logic [5:0]  DAC_MAX       = 6'h3f;
  // =====================================================
  // timing
  localparam longint CLK_HZ     = 200000000;
  localparam longint REF_HZ     = 8415;
  localparam int     REF_DIV    = int'(CLK_HZ / REF_HZ);
  localparam int     REF_CNT_W  = 15;
  localparam int     BASE_TICKS = 2104;
  localparam int     TEMP_HOT   = 150;
  localparam int     TEMP_COOL  = 140;
endpackage : fslc_pkg

// file: fslc_divider.sv
`timescale 1ns/1ps
// =====================================================
// programmable pulse divider: one out pulse per div_in enables
module fslc_divider (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       en_in,
  input  wire logic [7:0] div_in,
  output logic            pulse_out
);
  logic [7:0] cnt_r;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r     <= 8'h00;
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= 1'b0;
      if (en_in) begin
        if (cnt_r + 8'h01 >= div_in) begin
          cnt_r     <= 8'h00;
          pulse_out <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end
endmodule : fslc_divider

// file: fslc_top.sv
`timescale 1ns/1ps
module fslc_top (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_cmd_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       tach_pin_in,
  input  wire logic       cur_step_in,
  input  wire logic       thermal_open_cfg_in,
  input  wire logic       run_stop_in,
  input  wire logic [8:0] driver_temp_in,
  input  wire logic [6:0] thermal_speed_in,
  output logic [7:0]      reg_rdata_out,
  output logic [5:0]      fan_dac_out,
  output logic            fan_drive_en_out,
  output logic            thermal_open_out,
  output logic            fan_fail_out,
  output logic            full_speed_out,
  output logic            update_tick_out,
  output logic [1:0]      gain_sel_out
);
  // =====================================================
  // input synchronisers
  logic [1:0] tach_sync_r;
  logic [1:0] cur_sync_r;
  logic       tach_prev_r;
  logic       cur_prev_r;
  logic       tach_edge;
  logic       cur_edge;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tach_sync_r <= 2'h0;
      cur_sync_r  <= 2'h0;
      tach_prev_r <= 1'b0;
      cur_prev_r  <= 1'b0;
    end else begin
      tach_sync_r <= {tach_sync_r[0], tach_pin_in};
      cur_sync_r  <= {cur_sync_r[0], cur_step_in};
      tach_prev_r <= tach_sync_r[1];
      cur_prev_r  <= cur_sync_r[1];
    end
  end

  assign tach_edge = tach_sync_r[1] & ~tach_prev_r;
  assign cur_edge  = cur_sync_r[1] & ~cur_prev_r;

  // =====================================================
  // registers
  logic [7:0] gain_r;
  logic [7:0] presc_r;
  logic [7:0] fsdiv_r;
  logic [7:0] rate_r;
  logic [7:0] limit_r;
  logic [6:0] speed_r;
  logic [7:0] period_r;
  logic       open_loop;
  logic       thermal_open;

  assign open_loop    = gain_r[fslc_pkg::GAIN_DRV_BIT];
  assign thermal_open = thermal_open_cfg_in | open_loop;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gain_r <= fslc_pkg::GAIN_RST;
    end else if (reg_wr_in && reg_cmd_in == fslc_pkg::GAIN_WR_CMD) begin
      gain_r <= reg_wdata_in & fslc_pkg::GAIN_WMASK;
      if (!reg_wdata_in[fslc_pkg::GAIN_KEEP_BIT]) begin
        gain_r[fslc_pkg::GAIN_HI_BIT:fslc_pkg::GAIN_LO_BIT] <= fslc_pkg::GAIN_FLD_RST;
        gain_r[fslc_pkg::GAIN_KEEP_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      presc_r <= fslc_pkg::PRESC_RST;
      fsdiv_r <= fslc_pkg::FSDIV_RST;
      rate_r  <= fslc_pkg::RATE_RST;
      limit_r <= fslc_pkg::LIMIT_RST;
    end else if (reg_wr_in) begin
      unique case (reg_cmd_in)
        fslc_pkg::PRESC_WR_CMD: presc_r <= {6'h00, reg_wdata_in[1:0]};
        fslc_pkg::FSDIV_WR_CMD: fsdiv_r <= reg_wdata_in;
        fslc_pkg::RATE_WR_CMD:  rate_r  <= reg_wdata_in;
        fslc_pkg::LIMIT_WR_CMD: limit_r <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // speed value: written in thermal open loop, else follows thermal loop
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      speed_r <= 7'h00;
    end else if (thermal_open) begin
      if (reg_wr_in && reg_cmd_in == fslc_pkg::SPEED_WR_CMD) begin
        speed_r <= reg_wdata_in[6:0];
      end
    end else if (update_tick_out) begin
      speed_r <= thermal_speed_in;
    end
  end

  // =====================================================
  // reference chain: 8415 Hz base, full-scale divider
  logic [fslc_pkg::REF_CNT_W-1:0] base_cnt_r;
  logic                           base_tick_r;
  logic [7:0]                     fs_eff;
  logic                           ref_pulse;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      base_cnt_r  <= '0;
      base_tick_r <= 1'b0;
    end else if (base_cnt_r == fslc_pkg::REF_CNT_W'(fslc_pkg::REF_DIV - 1)) begin
      base_cnt_r  <= '0;
      base_tick_r <= 1'b1;
    end else begin
      base_cnt_r  <= base_cnt_r + 1'b1;
      base_tick_r <= 1'b0;
    end
  end

  assign fs_eff = (fsdiv_r < fslc_pkg::FSDIV_MIN) ? fslc_pkg::FSDIV_MIN : fsdiv_r;

  fslc_divider u_fs_div (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .en_in       (base_tick_r),
    .div_in      (fs_eff),
    .pulse_out   (ref_pulse)
  );

  // desired-speed reference: one of every span pulses per speed step
  function automatic logic [6:0] span_of(input logic [1:0] g);
    unique case (g)
      2'h0:    span_of = 7'h10;
      2'h1:    span_of = 7'h20;
      default: span_of = 7'h3f;
    endcase
  endfunction : span_of

  logic [1:0] gain_sel;
  logic [6:0] span;
  logic [6:0] phase_r;
  logic       ref_up;

  assign gain_sel = gain_r[fslc_pkg::GAIN_HI_BIT:fslc_pkg::GAIN_LO_BIT];
  assign span     = span_of(gain_sel);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_r <= 7'h00;
    end else if (ref_pulse) begin
      phase_r <= (phase_r + 7'h01 >= span) ? 7'h00 : phase_r + 7'h01;
    end
  end

  assign ref_up = ref_pulse && (phase_r < speed_r);

  // =====================================================
  // feedback prescaler
  logic       fb_raw;
  logic [2:0] pre_cnt_r;
  logic       fb_pulse;
  logic [2:0] pre_mask;

  assign fb_raw   = gain_r[fslc_pkg::GAIN_FB_BIT] ? cur_edge : tach_edge;
  assign pre_mask = 3'((4'h1 << presc_r[1:0]) - 4'h1);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_cnt_r <= 3'h0;
    end else if (fb_raw) begin
      pre_cnt_r <= (pre_cnt_r & pre_mask) == pre_mask ? 3'h0 : pre_cnt_r + 3'h1;
    end
  end

  assign fb_pulse = fb_raw && ((pre_cnt_r & pre_mask) == pre_mask) && !open_loop;

  // =====================================================
  // up/down loop counter and DAC
  logic [5:0] loop_cnt_r;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      loop_cnt_r <= 6'h00;
    end else if (ref_up && !fb_pulse && loop_cnt_r != fslc_pkg::DAC_MAX) begin
      loop_cnt_r <= loop_cnt_r + 6'h01;
    end else if (fb_pulse && !ref_up && loop_cnt_r != 6'h00) begin
      loop_cnt_r <= loop_cnt_r - 6'h01;
    end
  end

  // =====================================================
  // driver thermal shutdown with hysteresis
  logic drv_hot_r;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      drv_hot_r <= 1'b0;
    end else if (driver_temp_in > 9'(fslc_pkg::TEMP_HOT)) begin
      drv_hot_r <= 1'b1;
    end else if (driver_temp_in < 9'(fslc_pkg::TEMP_COOL)) begin
      drv_hot_r <= 1'b0;
    end
  end

  // =====================================================
  // update interval: BASE_TICKS * 2^((6 - code) mod 8) base ticks per step
  logic [24:0] upd_cnt_r;
  logic [24:0] upd_len;

  assign upd_len = 25'(fslc_pkg::BASE_TICKS) << (3'h6 - rate_r[2:0]);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      upd_cnt_r       <= '0;
      update_tick_out <= 1'b0;
    end else begin
      update_tick_out <= 1'b0;
      if (!run_stop_in && base_tick_r) begin
        if (upd_cnt_r + 25'h1 >= upd_len) begin
          upd_cnt_r       <= '0;
          update_tick_out <= 1'b1;
        end else begin
          upd_cnt_r <= upd_cnt_r + 25'h1;
        end
      end
    end
  end

  // =====================================================
  // period measurement and fan fail
  logic [7:0] per_cnt_r;
  logic       ovf_r;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      per_cnt_r <= 8'h00;
      period_r  <= 8'h00;
      ovf_r     <= 1'b0;
    end else if (tach_edge) begin
      period_r  <= per_cnt_r;
      per_cnt_r <= 8'h00;
      ovf_r     <= 1'b0;
    end else if (base_tick_r) begin
      if (per_cnt_r == 8'hff) begin
        ovf_r <= 1'b1;
      end else begin
        per_cnt_r <= per_cnt_r + 8'h01;
      end
    end
  end

  // =====================================================
  // outputs
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fan_dac_out      <= 6'h00;
      fan_drive_en_out <= 1'b0;
      thermal_open_out <= 1'b0;
      fan_fail_out     <= 1'b0;
      full_speed_out   <= 1'b0;
      gain_sel_out     <= 2'h0;
    end else begin
      if (open_loop) begin
        fan_dac_out <= speed_r[6] ? fslc_pkg::DAC_MAX : speed_r[5:0];
      end else begin
        fan_dac_out <= loop_cnt_r;
      end
      fan_drive_en_out <= ~drv_hot_r;
      thermal_open_out <= thermal_open;
      fan_fail_out     <= open_loop | ovf_r | (period_r > limit_r);
      full_speed_out   <= !open_loop && loop_cnt_r == fslc_pkg::DAC_MAX;
      gain_sel_out     <= gain_sel;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_cmd_in)
        fslc_pkg::GAIN_RD_CMD:   reg_rdata_out <= gain_r;
        fslc_pkg::PRESC_RD_CMD:  reg_rdata_out <= presc_r;
        fslc_pkg::FSDIV_RD_CMD:  reg_rdata_out <= fsdiv_r;
        fslc_pkg::RATE_RD_CMD:   reg_rdata_out <= rate_r;
        fslc_pkg::SPEED_RD_CMD:  reg_rdata_out <= {1'b0, speed_r};
        fslc_pkg::PERIOD_RD_CMD: reg_rdata_out <= period_r;
        fslc_pkg::LIMIT_RD_CMD:  reg_rdata_out <= limit_r;
        default:                 reg_rdata_out <= 8'h00;
      endcase
    end
  end
endmodule : fslc_top

// file: fslc_top_monitor.sv
`timescale 1ns/1ps
// =====================================================
// port-level checks on the fan loop block
module fslc_top_monitor (
  input wire logic       core_clk_in,
  input wire logic       nrst_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_cmd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       tach_pin_in,
  input wire logic       cur_step_in,
  input wire logic       thermal_open_cfg_in,
  input wire logic       run_stop_in,
  input wire logic [8:0] driver_temp_in,
  input wire logic [6:0] thermal_speed_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [5:0] fan_dac_out,
  input wire logic       fan_drive_en_out,
  input wire logic       thermal_open_out,
  input wire logic       fan_fail_out,
  input wire logic       full_speed_out,
  input wire logic       update_tick_out,
  input wire logic [1:0] gain_sel_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);
  // thermal open without config bit means fan open loop
  wire fan_open_w = thermal_open_out && !thermal_open_cfg_in;
  wire in_band_w  = driver_temp_in >= 9'h08c && driver_temp_in <= 9'h096;
  sequence s_gain_wr;
    reg_wr_in && reg_cmd_in == fslc_pkg::GAIN_WR_CMD;
  endsequence
  sequence s_open_held;
    fan_open_w [*3];
  endsequence
  property p_gain_clr;
    s_gain_wr ##0 !reg_wdata_in[7] |-> ##[1:2] gain_sel_out == 2'h0;
  endproperty
  property p_gain_set;
    s_gain_wr ##0 reg_wdata_in[7:5] == 3'h6 |-> ##[1:2] gain_sel_out == 2'h2;
  endproperty
  property p_drv_open;
    s_gain_wr ##0 reg_wdata_in[0] |-> ##[1:3] thermal_open_out;
  endproperty
  property p_fail_open;
    s_open_held |-> fan_fail_out;
  endproperty
  property p_full_open;
    s_open_held |-> !full_speed_out;
  endproperty
  property p_cfg_open;
    thermal_open_cfg_in [*2] |-> thermal_open_out;
  endproperty
  property p_hot;
    driver_temp_in > 9'h096 |-> ##[1:3] !fan_drive_en_out;
  endproperty
  property p_cool;
    (driver_temp_in < 9'h08c) [*3] |-> fan_drive_en_out;
  endproperty
  property p_band;
    in_band_w [*3] |-> $stable(fan_drive_en_out);
  endproperty
  property p_tick;
    update_tick_out |=> !update_tick_out;
  endproperty
  a_gain_clr: assert property (p_gain_clr) else $error("gain field kept");
  a_gain_set: assert property (p_gain_set) else $error("gain field lost");
  a_drv_open: assert property (p_drv_open) else $error("thermal loop closed");
  a_fail_open: assert property (p_fail_open) else $error("fail low in open loop");
  a_full_open: assert property (p_full_open) else $error("full flag in open loop");
  a_cfg_open: assert property (p_cfg_open) else $error("config open ignored");
  a_hot: assert property (p_hot) else $error("driver on when hot");
  a_cool: assert property (p_cool) else $error("driver off when cool");
  a_band: assert property (p_band) else $error("driver changed in band");
  a_tick: assert property (p_tick) else $error("tick too long");
endmodule : fslc_top_monitor

bind fslc_top fslc_top_monitor i_fslc_top_monitor (.core_clk_in, .nrst_in, .reg_wr_in,
  .reg_rd_in, .reg_cmd_in, .reg_wdata_in, .tach_pin_in, .cur_step_in, .thermal_open_cfg_in,
  .run_stop_in, .driver_temp_in, .thermal_speed_in, .reg_rdata_out, .fan_dac_out,
  .fan_drive_en_out, .thermal_open_out, .fan_fail_out, .full_speed_out, .update_tick_out,
  .gain_sel_out);

// file: fslc_fan_model.sv
`timescale 1ns/1ps
// =====================================================
// fan with tach output; period 0 means rotor stopped
module fslc_fan_model (
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        fan_on_in,
  input  wire logic [31:0] period_in,
  output logic             tach_out,
  output logic             cur_step_out
);
  logic [31:0] cnt_r;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= 32'h0;
    end else if (!fan_on_in || period_in == 32'h0) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= (cnt_r == period_in - 32'h1) ? 32'h0 : cnt_r + 32'h1;
    end
  end
  // stopped fan gives no edges; current steps with each pole
  assign tach_out     = fan_on_in && period_in != 32'h0 && cnt_r < 32'h8;
  assign cur_step_out = tach_out;
endmodule : fslc_fan_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic       core_clk_in, nrst_in, reg_wr_in, reg_rd_in, tach_pin_in, cur_step_in;
  logic       thermal_open_cfg_in, run_stop_in, fan_drive_en_out, thermal_open_out;
  logic       fan_fail_out, full_speed_out, update_tick_out;
  logic [7:0] reg_cmd_in, reg_wdata_in, reg_rdata_out, d, w, e;
  logic [8:0] driver_temp_in;
  logic [6:0] thermal_speed_in;
  logic [5:0] fan_dac_out;
  logic [1:0] gain_sel_out;
  logic [31:0] period;
  int         mismatches, samples_checked;
  logic [7:0] rcmd[5] = '{8'had, 8'hbb, 8'hbf, 8'hc1, 8'hb1};
  logic [7:0] rval[5] = '{8'h80, 8'h01, 8'hff, 8'h02, 8'hff};
  logic [8:0] tt[4]   = '{9'h097, 9'h091, 9'h08b, 9'h096};
  logic [7:0] te[4]   = '{8'h00, 8'h00, 8'h01, 8'h01};

  fslc_top i_fslc_top (.core_clk_in, .nrst_in, .reg_wr_in, .reg_rd_in, .reg_cmd_in,
    .reg_wdata_in, .tach_pin_in, .cur_step_in, .thermal_open_cfg_in, .run_stop_in,
    .driver_temp_in, .thermal_speed_in, .reg_rdata_out, .fan_dac_out, .fan_drive_en_out,
    .thermal_open_out, .fan_fail_out, .full_speed_out, .update_tick_out, .gain_sel_out);
  fslc_fan_model i_fslc_fan_model (.core_clk_in, .nrst_in, .fan_on_in(fan_drive_en_out),
    .period_in(period), .tach_out(tach_pin_in), .cur_step_out(cur_step_in));

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // =====================================================
  // helpers
  function automatic logic [7:0] gain_exp(input logic [7:0] v);
    return {1'b1, v[7] ? v[6:5] : 2'h0, 3'h0, v[1:0]};
  endfunction : gain_exp
  // limit for a 0.75 fail ratio; p is the tach period in clock cycles
  function automatic logic [7:0] lim_exp(input logic [31:0] p);
    return 8'((fslc_pkg::REF_HZ * p * 4) / (3 * fslc_pkg::CLK_HZ));
  endfunction : lim_exp
  function automatic logic [7:0] dac_exp(input logic [7:0] v);
    return v[6] ? 8'h3f : {2'h0, v[5:0]};
  endfunction : dac_exp
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
    samples_checked++;
    if (s !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    @(negedge core_clk_in);
    reg_wr_in = 1'b1;
    reg_cmd_in = c;
    reg_wdata_in = v;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] c);
    @(negedge core_clk_in);
    reg_rd_in = 1'b1;
    reg_cmd_in = c;
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    @(negedge core_clk_in);
    d = reg_rdata_out;
  endtask : rd
  task automatic settle();
    repeat (4) @(negedge core_clk_in);
  endtask : settle
  task print_verdict;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // =====================================================
  // main sequence
  initial begin
    {nrst_in, reg_wr_in, reg_rd_in, thermal_open_cfg_in, run_stop_in} = 5'h0;
    {reg_cmd_in, reg_wdata_in, thermal_speed_in} = 23'h0;
    driver_temp_in = 9'h019;
    period = 32'h0;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(32'h4fd23887));
    repeat (8) @(negedge core_clk_in);
    nrst_in = 1'b1;
    settle();
    for (int i = 0; i < 5; i++) begin
      rd(rcmd[i]);
      chk("reset value", d, rval[i]);
    end
    for (int i = 0; i < 8; i++) begin
      w = 8'($urandom);
      w[6:5] = 2'($urandom % 3);
      w[0] = 1'b0;
      if (i == 0) w = 8'h60;
      if (i == 1) w = 8'hc0;
      e = gain_exp(w);
      wr(fslc_pkg::GAIN_WR_CMD, w);
      rd(fslc_pkg::GAIN_RD_CMD);
      chk("gain", d, e);
      chk("gain_sel", {6'h0, gain_sel_out}, {6'h0, e[6:5]});
    end
    for (int i = 0; i < 4; i++) begin
      w = 8'($urandom);
      wr(fslc_pkg::PRESC_WR_CMD, w);
      rd(fslc_pkg::PRESC_RD_CMD);
      chk("prescaler", d, {6'h0, w[1:0]});
      wr(fslc_pkg::RATE_WR_CMD, w);
      rd(fslc_pkg::RATE_RD_CMD);
      chk("rate", d, w);
      w[7] = 1'b1;
      wr(fslc_pkg::FSDIV_WR_CMD, w);
      rd(fslc_pkg::FSDIV_RD_CMD);
      chk("full scale", d, w);
    end
    for (int i = 0; i < 4; i++) begin
      driver_temp_in = tt[i];
      settle();
      chk("drive enable", {7'h0, fan_drive_en_out}, te[i]);
    end
    driver_temp_in = 9'h019;
    wr(fslc_pkg::GAIN_WR_CMD, 8'h80);
    thermal_open_cfg_in = 1'b1;
    settle();
    chk("thermal open", {7'h0, thermal_open_out}, 8'h01);
    thermal_open_cfg_in = 1'b0;
    wr(fslc_pkg::GAIN_WR_CMD, 8'h81);
    settle();
    chk("thermal open", {7'h0, thermal_open_out}, 8'h01);
    chk("fan fail", {7'h0, fan_fail_out}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 8'h40 : 8'($urandom % 64);
      thermal_speed_in = 7'($urandom);
      run_stop_in = 1'($urandom);
      wr(fslc_pkg::SPEED_WR_CMD, w);
      settle();
      chk("dac", {2'h0, fan_dac_out}, dac_exp(w));
      rd(fslc_pkg::SPEED_RD_CMD);
      chk("speed", d, w);
    end
    run_stop_in = 1'b0;
    wr(fslc_pkg::GAIN_WR_CMD, 8'h80);
    // speed value is read-only with both loops closed
    wr(fslc_pkg::SPEED_WR_CMD, 8'h15);
    rd(fslc_pkg::SPEED_RD_CMD);
    chk("speed locked", d, w);
    chk("dac closed", {2'h0, fan_dac_out}, 8'h00);
    chk("full speed", {7'h0, full_speed_out}, 8'h00);
    // largest divide for the fast test fan
    wr(fslc_pkg::PRESC_WR_CMD, 8'h03);
    period = 32'h5dc0;
    repeat (20) @(negedge core_clk_in);
    chk("fan fail", {7'h0, fan_fail_out}, 8'h00);
    wr(fslc_pkg::LIMIT_WR_CMD, 8'h00);
    repeat (24040) @(negedge core_clk_in);
    chk("fan fail", {7'h0, fan_fail_out}, 8'h01);
    rd(fslc_pkg::PERIOD_RD_CMD);
    chk("period", d, 8'(period / fslc_pkg::REF_DIV));
    wr(fslc_pkg::LIMIT_WR_CMD, lim_exp(period));
    settle();
    chk("fan fail", {7'h0, fan_fail_out}, 8'h00);
    print_verdict();
  end

  initial begin
    #250000;
    mismatches++;
    print_verdict();
  end
endmodule : testbench
